//--- logic/pag_defines.svh
/*
  register indices, reset values and field positions of the port a block.
  assumes a 32-bit axi4-lite bus; byte address is four times the index.
*/
`ifndef PAG_DEFINES_SVH
`define PAG_DEFINES_SVH

`define PAG_IDX_EDGE 6'h0c
`define PAG_IDX_GATE 6'h0d
`define PAG_IDX_DATA 6'h10
`define PAG_IDX_DIR 6'h11
`define PAG_IDX_PU 6'h12
`define PAG_IDX_PD 6'h13
`define PAG_IDX_STAT 6'h14
`define PAG_IDX_MASK 6'h15

`define PAG_RST_PORT 8'h00
`define PAG_RST_GATE 8'hf9
`define PAG_RST_EDGE 2'h0
`define PAG_RST_EVT 2'h0

`define PAG_EVT_PIN 0
`define PAG_EVT_WAKE 1
`define PAG_IRQ_PIN_A 0
`define PAG_IRQ_PIN_B 5
`define PAG_SETTLE_CNT 2'h3

`define PAG_EDGE_BOTH 2'h0
`define PAG_EDGE_RISE 2'h1
`define PAG_EDGE_FALL 2'h2

`define PAG_RESP_OKAY 2'h0
`define PAG_RESP_SLVERR 2'h2

`endif

//--- logic/pag_pkg.sv
/*
  types shared by the port a block.
  assumes pag_defines.svh for the numbers.
*/
package pag_pkg;

  typedef enum logic [3:0] {
    PAG_REG_NONE,
    PAG_REG_EDGE,
    PAG_REG_GATE,
    PAG_REG_DATA,
    PAG_REG_DIR,
    PAG_REG_PU,
    PAG_REG_PD,
    PAG_REG_STAT,
    PAG_REG_MASK
  } pag_reg_t;

  typedef enum {
    PAG_WR_COLLECT,
    PAG_WR_RESP
  } pag_wr_t;

endpackage : pag_pkg

//--- logic/pag_pin_sync.sv
/*
  two-stage synchroniser for the eight port pins plus a history stage.
  assumes pins may change at any time relative to aclk.
*/
`timescale 1ns/1ps
module pag_pin_sync (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins
  input wire logic [7:0] pin_in,
  // synchronised levels
  output logic [7:0] pin_level,
  output logic [7:0] pin_prev
);

  logic [7:0] meta;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      // first stage feeds only the second stage
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta[i] <= 1'b0;
          pin_level[i] <= 1'b0;
          pin_prev[i] <= 1'b0;
        end else begin
          meta[i] <= pin_in[i];
          pin_level[i] <= meta[i];
          pin_prev[i] <= pin_level[i];
        end
      end
    end
  endgenerate

endmodule : pag_pin_sync

//--- logic/pag_port_a.sv
/*
  eight-bit gpio port a with pin interrupt and wake events, axi4-lite slave.
  assumes one clock aclk, synchronous active-low reset, pads outside.
*/
// Contract
// - direction bit 1 output, 0 input, reset 0
// - port data register, reset 0, drives outputs
// - pull-up enable per pin, reset 0
// - pull-down enable per pin, reset 0
// - gate bits 7:6 enable input and wake
// - gate bit 5 enables input, wake, irq
// - gate bits 4:3 enable input and wake
// - gate bit 0 enables input, wake, irq
// - edge field: both, rising, falling, 11 none
// - qualifying edge sets sticky pin flag
// - pin flag reaches irq only when enabled
`timescale 1ns/1ps
`include "pag_defines.svh"
module pag_port_a (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pads
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup_en,
  output logic [7:0] pin_pulldown_en,
  // events
  output logic wake_event,
  output logic irq
);

  function automatic pag_pkg::pag_reg_t reg_decode(input logic [7:0] addr);
    if (addr[1:0] != 2'h0) begin
      return pag_pkg::PAG_REG_NONE;
    end
    case (addr[7:2])
      `PAG_IDX_EDGE: return pag_pkg::PAG_REG_EDGE;
      `PAG_IDX_GATE: return pag_pkg::PAG_REG_GATE;
      `PAG_IDX_DATA: return pag_pkg::PAG_REG_DATA;
      `PAG_IDX_DIR: return pag_pkg::PAG_REG_DIR;
      `PAG_IDX_PU: return pag_pkg::PAG_REG_PU;
      `PAG_IDX_PD: return pag_pkg::PAG_REG_PD;
      `PAG_IDX_STAT: return pag_pkg::PAG_REG_STAT;
      `PAG_IDX_MASK: return pag_pkg::PAG_REG_MASK;
      default: return pag_pkg::PAG_REG_NONE;
    endcase
  endfunction : reg_decode

  function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] sel);
    case (sel)
      `PAG_EDGE_BOTH: return prev ^ cur;
      `PAG_EDGE_RISE: return !prev && cur;
      `PAG_EDGE_FALL: return prev && !cur;
      default: return 1'b0;
    endcase
  endfunction : edge_hit

  logic [7:0] pin_level;
  logic [7:0] pin_prev;
  logic [7:0] gate;
  logic [1:0] edge_sel;
  logic [1:0] status;
  logic [1:0] mask;
  logic [7:0] in_en;
  logic [7:0] wake_mask;
  logic [7:0] toggles;
  logic hit_a;
  logic hit_b;
  logic [1:0] evt_set;
  logic [1:0] next_status;
  logic [7:0] data_view;

  pag_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(pin_in),
    .pin_level(pin_level),
    .pin_prev(pin_prev)
  );

  // write path
  pag_pkg::pag_wr_t wr_state;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic w_strb0_q;
  logic wr_fire;
  logic next_aw_held;
  logic next_w_held;
  pag_pkg::pag_reg_t wr_sel;

  assign wr_fire = aw_held && w_held && (wr_state == pag_pkg::PAG_WR_COLLECT);
  assign wr_sel = reg_decode(aw_addr_q);
  assign next_aw_held = aw_held ? !wr_fire : (s_axi_awvalid && s_axi_awready);
  assign next_w_held = w_held ? !wr_fire : (s_axi_wvalid && s_axi_wready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_awready <= !next_aw_held;
      s_axi_wready <= !next_w_held;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb0_q <= s_axi_wstrb[0];
      end
    end
  end

  // response only after both halves are in hand
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= pag_pkg::PAG_WR_COLLECT;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PAG_RESP_OKAY;
    end else begin
      case (wr_state)
        pag_pkg::PAG_WR_COLLECT: begin
          if (wr_fire) begin
            wr_state <= pag_pkg::PAG_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == pag_pkg::PAG_REG_NONE) ? `PAG_RESP_SLVERR
                                                              : `PAG_RESP_OKAY;
          end
        end
        pag_pkg::PAG_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= pag_pkg::PAG_WR_COLLECT;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state <= pag_pkg::PAG_WR_COLLECT;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // port configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= `PAG_RST_PORT;
      pin_oe <= `PAG_RST_PORT;
      pin_pullup_en <= `PAG_RST_PORT;
      pin_pulldown_en <= `PAG_RST_PORT;
    end else if (wr_fire && w_strb0_q) begin
      case (wr_sel)
        pag_pkg::PAG_REG_DATA: pin_out <= w_data_q[7:0];
        pag_pkg::PAG_REG_DIR: pin_oe <= w_data_q[7:0];
        pag_pkg::PAG_REG_PU: pin_pullup_en <= w_data_q[7:0];
        pag_pkg::PAG_REG_PD: pin_pulldown_en <= w_data_q[7:0];
        default: begin
        end
      endcase
    end
  end

  // write-only gate and edge registers; reserved bits are not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate <= `PAG_RST_GATE;
      edge_sel <= `PAG_RST_EDGE;
    end else if (wr_fire && w_strb0_q) begin
      if (wr_sel == pag_pkg::PAG_REG_GATE) begin
        gate <= {w_data_q[7:3], 2'h0, w_data_q[0]};
      end
      if (wr_sel == pag_pkg::PAG_REG_EDGE) begin
        edge_sel <= w_data_q[1:0];
      end
    end
  end

  // edges wait until the history stage holds real levels; earlier toggles are lost
  logic [1:0] settle_cnt;
  logic settled;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt <= 2'h0;
    end else if (!settled) begin
      settle_cnt <= settle_cnt + 2'h1;
    end
  end
  assign settled = (settle_cnt == `PAG_SETTLE_CNT);

  // pins 2:1 have no gate bit, so their input is always on
  assign in_en = {gate[7:3], 2'h3, gate[0]};
  assign wake_mask = {gate[7:3], 2'h0, gate[0]};
  assign toggles = (pin_level ^ pin_prev) & wake_mask & {8{settled}};
  assign hit_a = settled && in_en[`PAG_IRQ_PIN_A] && edge_hit(pin_prev[`PAG_IRQ_PIN_A],
    pin_level[`PAG_IRQ_PIN_A], edge_sel);
  assign hit_b = settled && in_en[`PAG_IRQ_PIN_B] && edge_hit(pin_prev[`PAG_IRQ_PIN_B],
    pin_level[`PAG_IRQ_PIN_B], edge_sel);
  assign evt_set = {|toggles, hit_a || hit_b};

  // read path
  logic rd_fire;
  logic stat_clr;
  pag_pkg::pag_reg_t rd_sel;

  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_sel = reg_decode(s_axi_araddr);
  assign stat_clr = rd_fire && (rd_sel == pag_pkg::PAG_REG_STAT);
  // a gated input reads as zero rather than floating
  assign data_view = (pin_out & pin_oe) | (pin_level & ~pin_oe & in_en);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PAG_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= (rd_sel == pag_pkg::PAG_REG_NONE) ? `PAG_RESP_SLVERR : `PAG_RESP_OKAY;
      case (rd_sel)
        pag_pkg::PAG_REG_DATA: s_axi_rdata <= {24'h000000, data_view};
        pag_pkg::PAG_REG_DIR: s_axi_rdata <= {24'h000000, pin_oe};
        pag_pkg::PAG_REG_PU: s_axi_rdata <= {24'h000000, pin_pullup_en};
        pag_pkg::PAG_REG_PD: s_axi_rdata <= {24'h000000, pin_pulldown_en};
        pag_pkg::PAG_REG_STAT: s_axi_rdata <= {30'h0, status};
        pag_pkg::PAG_REG_MASK: s_axi_rdata <= {30'h0, mask};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // sticky events; a set in the clearing cycle survives
  assign next_status = (status & ~{2{stat_clr}}) | evt_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= `PAG_RST_EVT;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= `PAG_RST_EVT;
    end else if (wr_fire && w_strb0_q && (wr_sel == pag_pkg::PAG_REG_MASK)) begin
      mask <= w_data_q[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
      wake_event <= 1'b0;
    end else begin
      irq <= |(next_status & mask);
      wake_event <= |toggles;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence reg_wr_s(pag_pkg::pag_reg_t r);
    wr_fire && w_strb0_q && (wr_sel == r);
  endsequence

  sequence no_pin_hit_s;
    !(hit_a || hit_b) && !$past(hit_a || hit_b);
  endsequence

  dir_reset_a: assert property ($rose(aresetn) |-> pin_oe == 8'h00)
    else $error("direction not cleared by reset");

  data_drive_a: assert property (reg_wr_s(pag_pkg::PAG_REG_DATA) |=>
    pin_out == $past(w_data_q[7:0]))
    else $error("port data write not driven");

  pullup_wr_a: assert property (reg_wr_s(pag_pkg::PAG_REG_PU) ##1 1'b1 |->
    pin_pullup_en == $past(w_data_q[7:0]))
    else $error("pull-up write lost");

  pulldown_wr_a: assert property (reg_wr_s(pag_pkg::PAG_REG_PD) |=>
    pin_pulldown_en == $past(w_data_q[7:0]) [*2])
    else $error("pull-down write lost");

  wake_high_a: assert property (|(toggles[7:6]) |=> wake_event && status[1])
    else $error("pin 7/6 toggle gave no wake");

  pin_b_gate_a: assert property (!gate[5] && !gate[0] |=> !$rose(status[0]))
    else $error("gated pins raised interrupt");

  wake_mid_a: assert property ((pin_level[4:3] != pin_prev[4:3]) && !gate[4] && !gate[3]
    && (toggles == 8'h00) |=> !wake_event)
    else $error("gated pins 4/3 woke device");

  pin_a_rise_a: assert property (settled && gate[0] && edge_sel == `PAG_EDGE_RISE &&
    !pin_prev[0] && pin_level[0] |=> status[0] ##1 status[0] || $past(stat_clr))
    else $error("pin 0 rising edge missed");

  edge_resvd_a: assert property (edge_sel == 2'h3 [*2] |-> !$rose(status[0]))
    else $error("reserved edge code raised interrupt");

  flag_sticky_a: assert property (status[0] && !stat_clr |=> status[0])
    else $error("pin flag dropped without read");

  flag_cause_a: assert property ($rose(status[0]) |-> $past(hit_a || hit_b))
    else $error("pin flag set without edge");

  irq_mask_a: assert property (!mask[0] && !mask[1] [*2] |-> !irq)
    else $error("masked flag reached irq");

  data_read_a: assert property ((rd_fire && rd_sel == pag_pkg::PAG_REG_DATA)
    and no_pin_hit_s |=> s_axi_rdata[7:0] == (($past(pin_out) & $past(pin_oe))
    | ($past(pin_level) & ~$past(pin_oe) & $past(in_en))))
    else $error("port data read wrong");

endmodule : pag_port_a

//--- tb/pag_pad_model.sv
/*
  pad model for port a: pins, pulls and an outside driver.
  assumes the bench moves ext_en and ext_val just after a clock edge.
*/
`timescale 1ns/1ps
module pag_pad_model (
  // clock
  input wire logic aclk,
  // from the port
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  input wire logic [7:0] pin_pulldown_en,
  // outside driver
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // to the port
  output logic [7:0] pin_in
);
  logic [7:0] held = 8'h00;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pin_pullup_en[i] && !pin_pulldown_en[i]) begin
        pin_in[i] = 1'b1;
      end else if (pin_pulldown_en[i] && !pin_pullup_en[i]) begin
        pin_in[i] = 1'b0;
      end else begin
        // floating pad keeps no level: show the opposite of the last one
        pin_in[i] = ~held[i];
      end
    end
  end
  always @(posedge aclk) begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i] || ext_en[i] || (pin_pullup_en[i] ^ pin_pulldown_en[i])) begin
        held[i] <= pin_in[i];
      end
    end
  end
endmodule : pag_pad_model

//--- tb/tb.sv
/*
  self-checking bench for pag_port_a: axi4-lite tasks and scripted tests.
  assumes pag_pad_model for the pins and one 200 mhz clock.
*/
`timescale 1ns/1ps
`include "pag_defines.svh"
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd_v;
  logic [1:0] rd_r;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pullup_en, pin_pulldown_en;
  logic wake_event, irq;
  logic [7:0] ext_en = 8'hff;
  logic [7:0] ext_val = 8'h00;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int wakes = 0;
  int w0;
  int pins[2] = '{0, 5};
  localparam logic [1:0] OK = `PAG_RESP_OKAY;
  localparam logic [1:0] ERR = `PAG_RESP_SLVERR;
  localparam logic [7:0] A_EDGE = {`PAG_IDX_EDGE, 2'b00};
  localparam logic [7:0] A_GATE = {`PAG_IDX_GATE, 2'b00};
  localparam logic [7:0] A_DATA = {`PAG_IDX_DATA, 2'b00};
  localparam logic [7:0] A_DIR = {`PAG_IDX_DIR, 2'b00};
  localparam logic [7:0] A_PU = {`PAG_IDX_PU, 2'b00};
  localparam logic [7:0] A_PD = {`PAG_IDX_PD, 2'b00};
  localparam logic [7:0] A_STAT = {`PAG_IDX_STAT, 2'b00};
  localparam logic [7:0] A_MASK = {`PAG_IDX_MASK, 2'b00};

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  pag_port_a dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
    .pin_oe, .pin_pullup_en, .pin_pulldown_en, .wake_event, .irq);

  pag_pad_model pads (.aclk, .pin_out, .pin_oe, .pin_pullup_en, .pin_pulldown_en,
    .ext_en, .ext_val, .pin_in);

  // pre-edge sample, so each one-cycle pulse counts once
  always @(posedge aclk) begin
    cycles++;
    if (wake_event === 1'b1) begin
      wakes++;
    end
    if (cycles == 5000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s resp %h exp %h", $time, m, got, exp);
    end
  endtask : chk_resp

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  // readiness is sampled at the falling edge, where it equals the rising-edge value
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
      input logic [1:0] er);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ad = ad || (s_axi_awready === 1'b1);
      wd = wd || (s_axi_wready === 1'b1);
      @(posedge aclk);
      if (ad) begin
        s_axi_awvalid <= 1'b0;
      end
      if (wd) begin
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk_resp(s_axi_bresp, er, "bresp");
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] r;
    rd(a, v, r);
    chk(v, {24'h0, exp}, "rdata");
    chk_resp(r, er, "rresp");
  endtask : rdc

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    ext_val <= 8'ha5;
    tick(6);
    chk({pin_out, pin_oe, pin_pullup_en, pin_pulldown_en}, 32'h0, "pads");
    rdc(A_DATA, 8'ha5, OK);
    rdc(A_DIR, 8'h00, OK);
    rdc(A_PU, 8'h00, OK);
    rdc(A_PD, 8'h00, OK);
    wr(A_DIR, 8'hf0, 4'h1, OK);
    wr(A_DATA, 8'h3c, 4'h1, OK);
    wr(A_PU, 8'h0f, 4'h1, OK);
    wr(A_PD, 8'h30, 4'h1, OK);
    tick(1);
    chk({pin_out, pin_oe, pin_pullup_en, pin_pulldown_en}, 32'h3cf00f30, "pads");
    rdc(A_DATA, 8'h35, OK);
    rdc(A_PD, 8'h30, OK);
    wr(A_DIR, 8'hff, 4'h0, OK);
    rdc(A_DIR, 8'hf0, OK);
    wr(8'h41, 8'hff, 4'h1, ERR);
    wr(8'h60, 8'hff, 4'h1, ERR);
    rdc(A_DATA, 8'h35, OK);
    rdc(8'h60, 8'h00, ERR);
    rdc(A_EDGE, 8'h00, OK);
    wr(A_DIR, 8'h00, 4'h1, OK);
    wr(A_PU, 8'hff, 4'h1, OK);
    wr(A_PD, 8'h00, 4'h1, OK);
    ext_en <= 8'h00;
    tick(6);
    rdc(A_DATA, 8'hff, OK);
    wr(A_PD, 8'hff, 4'h1, OK);
    wr(A_PU, 8'h00, 4'h1, OK);
    tick(6);
    rdc(A_DATA, 8'h00, OK);
    ext_val <= 8'h00;
    ext_en <= 8'hff;
    wr(A_MASK, 8'h03, 4'h1, OK);
    wr(A_GATE, 8'h00, 4'h1, OK);
    tick(6);
    rd(A_STAT, rd_v, rd_r);
    w0 = wakes;
    ext_val <= 8'hff;
    tick(6);
    rdc(A_DATA, 8'h06, OK);
    chk(wakes, w0, "wakes");
    rdc(A_STAT, 8'h00, OK);
    chk({31'h0, irq}, 32'h0, "irq");
    wr(A_GATE, 8'hf9, 4'h1, OK);
    ext_val <= 8'h00;
    tick(6);
    chk(wakes, w0 + 1, "wakes");
    chk({31'h0, irq}, 32'h1, "irq");
    rdc(A_STAT, 8'h03, OK);
    tick(2);
    chk({31'h0, irq}, 32'h0, "irq");
    wr(A_MASK, 8'h01, 4'h1, OK);
    rdc(A_MASK, 8'h01, OK);
    for (int c = 0; c < 4; c++) begin
      wr(A_EDGE, 8'(c), 4'h1, OK);
      foreach (pins[i]) begin
        ext_val[pins[i]] <= 1'b1;
        tick(6);
        chk({31'h0, irq}, {31'h0, (c < 2)}, "irq");
        rdc(A_STAT, {6'h0, 1'b1, (c < 2)}, OK);
        ext_val[pins[i]] <= 1'b0;
        tick(6);
        rdc(A_STAT, {6'h0, 1'b1, (c == 0 || c == 2)}, OK);
      end
    end
    wr(A_MASK, 8'h00, 4'h1, OK);
    wr(A_EDGE, 8'h00, 4'h1, OK);
    ext_val[0] <= 1'b1;
    tick(6);
    chk({31'h0, irq}, 32'h0, "irq");
    rdc(A_STAT, 8'h03, OK);
    foreach (pins[i]) begin
      wr(A_GATE, 8'hf9 & ~(8'h01 << pins[i]), 4'h1, OK);
      ext_val[pins[i]] <= ~ext_val[pins[i]];
      tick(6);
      rdc(A_STAT, 8'h00, OK);
    end
    summarize();
  end
endmodule : tb
